// *** logic/asrc_ctrl.sv ***
// Purpose: Host controller driving an asynchronous 64K x 16 static RAM
// Assumes: Requests synchronous to core_clk; SRAM pins timed from registers
// Notes: One access at a time; req_ready low while busy
`timescale 1ns/100ps
module asrc_ctrl (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_byte_en,
	output logic req_ready,
	output logic rsp_valid,
	output logic [asrc_pkg::DATA_W-1:0] rsp_rdata,
	output logic [asrc_pkg::ADDR_W-1:0] sram_addr,
	output logic chip_select_n,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic lower_byte_enable_n,
	output logic upper_byte_enable_n,
	input wire logic [asrc_pkg::DATA_W-1:0] sram_data_i,
	output logic [asrc_pkg::DATA_W-1:0] sram_data_o,
	output logic [asrc_pkg::DATA_W-1:0] sram_data_oe
);
	asrc_pkg::asrc_state_t state_r;
	asrc_pkg::asrc_state_t state_nxt;
	logic [asrc_pkg::ADDR_W-1:0] addr_r;
	logic [asrc_pkg::DATA_W-1:0] wdata_r;
	logic [1:0] ben_r;
	logic cs_n_r;
	logic oe_n_r;
	logic we_n_r;
	logic ble_n_r;
	logic bhe_n_r;
	logic ready_r;
	logic rsp_valid_r;
	logic [asrc_pkg::DATA_W-1:0] rdata_r;
	logic tmr_load;
	logic [asrc_pkg::CNT_W-1:0] tmr_val;
	logic tmr_done;
	wire take = ready_r && req_valid;
	wire in_idle = (state_r == asrc_pkg::ASRC_IDLE);
	wire in_read = (state_r == asrc_pkg::ASRC_READ);
	wire in_write = (state_r == asrc_pkg::ASRC_WRITE);
	// Empty byte mask has nothing to select; treated as a full word
	wire [1:0] ben_sel = (req_byte_en == 2'h0) ? 2'h3 : req_byte_en;
	wire rd_end = in_read && tmr_done;
	wire wr_end = in_write && tmr_done;
	// Host drives data only inside the write pulse, after the memory has
	// been told to let go by output enable high and write enable low.
	wire drive_lo = in_write && !tmr_done && ben_r[0];
	wire drive_hi = in_write && !tmr_done && ben_r[1];

	asrc_timer u_timer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	asrc_lane u_lane (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.wdata(wdata_r),
		.drive_lo(drive_lo),
		.drive_hi(drive_hi),
		.data_o(sram_data_o),
		.data_oe(sram_data_oe)
	);

	always_comb begin
		state_nxt = state_r;
		tmr_load = 1'b0;
		tmr_val = asrc_pkg::RD_CNT;
		case (state_r)
			asrc_pkg::ASRC_IDLE: begin
				if (take && req_write) begin
					state_nxt = asrc_pkg::ASRC_WRITE;
					tmr_load = 1'b1;
					tmr_val = asrc_pkg::WP_CNT;
				end else if (take) begin
					state_nxt = asrc_pkg::ASRC_READ;
					tmr_load = 1'b1;
					tmr_val = asrc_pkg::RD_CNT;
				end
			end
			asrc_pkg::ASRC_READ: begin
				if (tmr_done) begin
					state_nxt = asrc_pkg::ASRC_RTURN;
					tmr_load = 1'b1;
					tmr_val = asrc_pkg::TURN_CNT;
				end
			end
			asrc_pkg::ASRC_RTURN: begin
				if (tmr_done) begin
					state_nxt = asrc_pkg::ASRC_IDLE;
				end
			end
			asrc_pkg::ASRC_WRITE: begin
				if (tmr_done) begin
					state_nxt = asrc_pkg::ASRC_WREC;
					tmr_load = 1'b1;
					tmr_val = asrc_pkg::REC_CNT;
				end
			end
			asrc_pkg::ASRC_WREC: begin
				if (tmr_done) begin
					state_nxt = asrc_pkg::ASRC_IDLE;
				end
			end
			default: begin
				state_nxt = asrc_pkg::ASRC_IDLE;
			end
		endcase
	end

	// Pin next values: strobes fall on the same edge that latches address and data,
	// so address changes in the same cycle as select, byte enables and write enable.
	wire cs_n_nxt = !((in_idle && take) || (in_read && !tmr_done) || (in_write && !tmr_done));
	wire oe_n_nxt = !((in_idle && take && !req_write) || (in_read && !tmr_done));
	// Write enable falls together with select and byte enables, so outputs stay off
	wire we_n_nxt = !((in_idle && take && req_write) || (in_write && !tmr_done));
	wire [1:0] ben_cur = (in_idle && take) ? ben_sel : ben_r;
	wire lane_act = !cs_n_nxt;
	wire ble_n_nxt = !(lane_act && ben_cur[0]);
	wire bhe_n_nxt = !(lane_act && ben_cur[1]);
	// Next ready: accept only once the bus is quiet again
	wire ready_nxt = (in_idle && !take) || ((state_r == asrc_pkg::ASRC_RTURN) && tmr_done) ||
		((state_r == asrc_pkg::ASRC_WREC) && tmr_done);

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_r <= asrc_pkg::ASRC_IDLE;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ready_r <= ready_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			addr_r <= asrc_pkg::ADDR_RST;
			wdata_r <= asrc_pkg::DATA_RST;
			ben_r <= 2'h0;
		end else if (take) begin
			// Address held through the whole cycle and past write end
			addr_r <= req_addr;
			wdata_r <= req_wdata;
			ben_r <= ben_sel;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cs_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			ble_n_r <= 1'b1;
			bhe_n_r <= 1'b1;
		end else begin
			// Select and byte enables span the full write pulse and end with it
			cs_n_r <= cs_n_nxt;
			oe_n_r <= oe_n_nxt;
			we_n_r <= we_n_nxt;
			ble_n_r <= ble_n_nxt;
			bhe_n_r <= bhe_n_nxt;
		end
	end

	// Sampled on the last strobe cycle, after access time has elapsed;
	// read data from unselected lanes is forced to zero.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rsp_valid_r <= 1'b0;
			rdata_r <= asrc_pkg::DATA_RST;
		end else begin
			rsp_valid_r <= rd_end || wr_end;
			if (rd_end) begin
				rdata_r <= sram_data_i & {{8{ben_r[1]}}, {8{ben_r[0]}}};
			end
		end
	end

	assign req_ready = ready_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_rdata = rdata_r;
	assign sram_addr = addr_r;
	assign chip_select_n = cs_n_r;
	assign output_enable_n = oe_n_r;
	assign write_enable_n = we_n_r;
	assign lower_byte_enable_n = ble_n_r;
	assign upper_byte_enable_n = bhe_n_r;
endmodule // asrc_ctrl

// *** logic/asrc_lane.sv ***
// Purpose: Per-bit data pad control for the shared SRAM data bus
// Assumes: Pad resolution is done outside the design
// Notes: Output enable is registered so the pin never glitches
`timescale 1ns/100ps
module asrc_lane (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [asrc_pkg::DATA_W-1:0] wdata,
	input wire logic drive_lo,
	input wire logic drive_hi,
	output logic [asrc_pkg::DATA_W-1:0] data_o,
	output logic [asrc_pkg::DATA_W-1:0] data_oe
);
	localparam int HALF = asrc_pkg::DATA_W / 2;
	genvar i;
	generate
		for (i = 0; i < asrc_pkg::DATA_W; i++) begin : g_bit
			logic oe_r;
			logic d_r;
			wire sel = (i < HALF) ? drive_lo : drive_hi;
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					oe_r <= 1'b0;
					d_r <= 1'b0;
				end else begin
					oe_r <= sel;
					d_r <= wdata[i];
				end
			end
			assign data_o[i] = d_r;
			assign data_oe[i] = oe_r;
		end
	endgenerate
endmodule // asrc_lane

// *** logic/asrc_pkg.sv ***
// Purpose: Constants for the asynchronous 64K x 16 SRAM host controller
// Assumes: core_clk at 125 MHz (8 ns period), slow speed grade timing
// Notes: Counts except write recovery are derived from the times, least times rounded up
package asrc_pkg;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	// Slow grade times in ns
	localparam int T_RC_NS = 20;
	localparam int T_AA_NS = 20;
	localparam int T_OHZ_NS = 8;
	localparam int T_WC_NS = 20;
	localparam int T_AW_NS = 12;
	localparam int T_WP_NS = 12;
	localparam int T_DW_NS = 10;
	localparam int T_WHZ_NS = 8;
	localparam int T_CLZ_NS = 5;
	// Round up to whole cycles, at least one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction
	// Read strobe held for access time plus one sample margin cycle
	localparam int RD_CYC = ns_to_cyc(T_AA_NS) + 1;
	localparam int RD_TURN_CYC = ns_to_cyc(T_OHZ_NS);
	// Write pulse long enough for both pulse width and bus turn-off plus data setup
	localparam int WP_CYC = (ns_to_cyc(T_WP_NS) > ns_to_cyc(T_WHZ_NS + T_DW_NS)) ?
		ns_to_cyc(T_WP_NS) : ns_to_cyc(T_WHZ_NS + T_DW_NS);
	localparam int WR_REC_CYC = 1;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC - 1);
	localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(RD_TURN_CYC - 1);
	localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC - 1);
	localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(WR_REC_CYC - 1);
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	typedef enum logic [2:0] {
		ASRC_IDLE = 3'b000,
		ASRC_READ = 3'b001,
		ASRC_RTURN = 3'b011,
		ASRC_WRITE = 3'b100,
		ASRC_WREC = 3'b101
	} asrc_state_t;
endpackage

// *** logic/asrc_timer.sv ***
// Purpose: Down counter timing each phase of an SRAM cycle
// Assumes: Load takes precedence over counting
// Notes: done is high while the count is zero
`timescale 1ns/100ps
module asrc_timer (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [asrc_pkg::CNT_W-1:0] load_val,
	output logic done
);
	logic [asrc_pkg::CNT_W-1:0] cnt_r;
	logic [asrc_pkg::CNT_W-1:0] cnt_nxt;
	assign done = (cnt_r == '0);
	assign cnt_nxt = load ? load_val : (done ? cnt_r : cnt_r - 4'h1);
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule // asrc_timer

// *** sim/asrc_checker.sv ***
// Purpose: Pin timing checks for the SRAM host controller
// Assumes: 8 ns clock, slow grade counts
// Notes: Bound to asrc_ctrl from the bench
`timescale 1ns/100ps
module asrc_checker (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [asrc_pkg::ADDR_W-1:0] sram_addr,
	input wire logic chip_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic lower_byte_enable_n,
	input wire logic upper_byte_enable_n,
	input wire logic [asrc_pkg::DATA_W-1:0] sram_data_oe
);
	wire host_drv = |sram_data_oe;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence wr_low;
		!write_enable_n [*3];
	endsequence
	sequence rd_low;
		(!output_enable_n && !chip_select_n) [*4];
	endsequence
	chk_read_we_high: assert property (!output_enable_n |-> write_enable_n)
		else $error("write enable low in read");
	chk_write_pulse: assert property ($fell(write_enable_n) |-> wr_low ##1 write_enable_n [*2])
		else $error("write pulse length");
	chk_write_select: assert property (!write_enable_n |-> !chip_select_n && !(lower_byte_enable_n && upper_byte_enable_n))
		else $error("write without select");
	chk_data_setup: assert property ($rose(write_enable_n) |-> $past(host_drv) && $past(host_drv, 2))
		else $error("write data setup short");
	chk_write_addr: assert property (!write_enable_n && !$past(write_enable_n) |-> $stable(sram_addr))
		else $error("address moved in write");
	chk_read_addr: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(sram_addr))
		else $error("address moved while selected");
	chk_no_contend: assert property (host_drv |-> output_enable_n && !write_enable_n && !$past(write_enable_n))
		else $error("host drives into memory");
	chk_read_len: assert property ($fell(output_enable_n) |-> rd_low ##1 output_enable_n && rsp_valid)
		else $error("read strobe length");
	chk_idle_off: assert property (req_ready |-> chip_select_n && !host_drv)
		else $error("bus active while idle");
endmodule // asrc_checker

// *** sim/asrc_ctrl_bench.sv ***
// Purpose: Self-checking bench for the SRAM host controller
// Assumes: Inputs change on the falling edge
// Notes: Addresses kept to eight words so reads hit written data
`timescale 1ns/100ps
module asrc_ctrl_bench;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0] req_byte_en = 2'h0;
	logic req_ready, rsp_valid, chip_select_n, output_enable_n, write_enable_n, lower_byte_enable_n, upper_byte_enable_n;
	logic [15:0] rsp_rdata, sram_addr, sram_data_i, sram_data_o, sram_data_oe;
	logic [15:0] ref_mem [0:7] = '{default: 16'h0000};
	int mismatches = 0;
	int tests_run = 0;
	asrc_ctrl u_dut (.*);
	asrc_sram_model u_mem (.*);
	always #4 core_clk = ~core_clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] lane_mask(input logic [1:0] be);
		return {{8{be[1] || be == 2'h0}}, {8{be[0] || be == 2'h0}}};
	endfunction
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic access(input logic wr, input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		req_valid = 1'b1;
		req_write = wr;
		req_addr = {13'h0000, a};
		req_wdata = d;
		req_byte_en = be;
		@(negedge core_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		check(16'(n), wr ? 16'h0003 : 16'h0004);
		if (wr) ref_mem[a] = (ref_mem[a] & ~lane_mask(be)) | (d & lane_mask(be));
		else check(rsp_rdata, ref_mem[a] & lane_mask(be));
	endtask
	initial begin
		void'($urandom(5));
		repeat (16) @(negedge core_clk);
		check({10'h000, req_ready, chip_select_n, output_enable_n, write_enable_n, lower_byte_enable_n,
			upper_byte_enable_n}, 16'h001F);
		check(sram_data_oe, 16'h0000);
		reset_n = 1'b1;
		$display("test reset done");
		// Every lane code written, then read back with every code
		for (int w = 0; w < 4; w++) begin
			access(1'b1, 3'(w), 16'hC35A ^ 16'(w * 16'h1111), 2'(w));
			for (int r = 0; r < 4; r++) access(1'b0, 3'(w), 16'h0000, 2'(r));
		end
		$display("test lanes done");
		repeat (60) access(1'($urandom), 3'($urandom), 16'($urandom), 2'($urandom));
		$display("test random done");
		end_sim;
	end
	initial begin
		#60000;
		mismatches++;
		end_sim;
	end
endmodule // asrc_ctrl_bench
bind asrc_ctrl asrc_checker u_chk (.*);

// *** sim/asrc_sram_model.sv ***
// Purpose: Behavioural 64K x 16 asynchronous SRAM
// Assumes: Slow grade delays
// Notes: Released lines show a moving pattern, no pull
`timescale 1ns/100ps
module asrc_sram_model (
	input wire logic [15:0] sram_addr,
	input wire logic chip_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic lower_byte_enable_n,
	input wire logic upper_byte_enable_n,
	input wire logic [15:0] sram_data_o,
	input wire logic [15:0] sram_data_oe,
	output wire logic [15:0] sram_data_i
);
	logic [15:0] mem [0:65535];
	logic [15:0] noise = 16'hA5C3;
	wire [15:0] lane = {{8{!upper_byte_enable_n}}, {8{!lower_byte_enable_n}}};
	wire rd_on = !chip_select_n && !output_enable_n && write_enable_n;
	wire wr_on = !chip_select_n && !write_enable_n;
	wire [15:0] mem_oe_raw = rd_on ? lane : 16'h0000;
	wire [15:0] mem_oe;
	wire [15:0] rd_q;
	// Late turn-on, still inside the turn-off limit
	assign #5 mem_oe = mem_oe_raw;
	assign #20 rd_q = mem[sram_addr];
	always #4 noise = ~noise;
	assign sram_data_i = (sram_data_oe & sram_data_o) | (mem_oe & rd_q) | (~(sram_data_oe | mem_oe) & noise);
	initial for (int i = 0; i < 65536; i++) mem[i] = 16'h0000;
	always @* begin
		if (wr_on && !lower_byte_enable_n && sram_data_oe[0]) mem[sram_addr][7:0] = sram_data_o[7:0];
		if (wr_on && !upper_byte_enable_n && sram_data_oe[8]) mem[sram_addr][15:8] = sram_data_o[15:8];
	end
endmodule // asrc_sram_model
